// file: design/clk_div_stage.sv
// One divide-by-two toggle stage driven by an enable tick.
module clk_div_stage
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic tick_in,
   output logic      tick_out
);
   logic ph_r;
   logic ph_nxt;

   always_comb
   begin
      ph_nxt = tick_in ? ~ph_r : ph_r;
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         ph_r <= 1'b0;
      else
         ph_r <= ph_nxt;
   end

   assign tick_out = tick_in & ph_r;
endmodule

// file: design/duty_pulse_gen.sv
// Charge/discharge pulse generator over a 32-slot period.
module duty_pulse_gen
   import lcd_ctl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        run,
   input  wire logic        tick,
   input  wire logic [3:0]  duty_code,
   output logic             pulse
);
   logic [SLOT_W-1:0] slot_r;
   logic [SLOT_W-1:0] slot_nxt;
   logic [SLOT_W:0]   high_slots;
   logic              pulse_r;
   logic              pulse_nxt;

   always_comb
   begin
      high_slots = '0;
      casez (duty_code)
         4'b0000: high_slots = 6'(DUTY_SLOTS);
         4'b0111: high_slots = 6'h00;
         4'b0???: high_slots = 6'({duty_code[2:0], 2'b00});
         4'b10??: high_slots = 6'h02;
         4'b11??: high_slots = 6'h01;
         default: high_slots = 6'h00;
      endcase
      slot_nxt  = run ? (tick ? SLOT_W'(slot_r + 5'h01) : slot_r) : '0;
      pulse_nxt = run & ({1'b0, slot_r} < high_slots);
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         slot_r  <= '0;
         pulse_r <= 1'b0;
      end
      else
      begin
         slot_r  <= slot_nxt;
         pulse_r <= pulse_nxt;
      end
   end

   assign pulse = pulse_r;
endmodule

// file: design/lcd_ctl_pkg.sv
// Package with register map, field positions, reset values and codes of the LCD drive control.
package lcd_ctl_pkg;
   localparam logic [7:0] ADDR_LCD_CONTROL        = 8'hc1;
   localparam logic [7:0] ADDR_LCD_CONTROL_SECOND = 8'hc2;
   // Control register fields.
   localparam int         POS_POWER   = 6;
   localparam int         POS_RUN     = 5;
   localparam int         POS_SHOW    = 4;
   localparam int         POS_CKS_HI  = 3;
   localparam int         POS_CKS_LO  = 0;
   localparam logic [7:0] CTL_RESET   = 8'h80;
   localparam logic [7:0] CTL_RO_MASK = 8'h80;
   // Second control register fields.
   localparam int         POS_WAVE_B  = 7;
   localparam int         POS_DUTY_HI = 3;
   localparam int         POS_DUTY_LO = 0;
   localparam int         POS_SPARE   = 4;
   localparam logic [7:0] CTL2_RESET   = 8'h60;
   localparam logic [7:0] CTL2_RO_MASK = 8'h60;
   // Duty period of 32 slots; fraction given in slots.
   localparam int         DUTY_SLOTS = 32;
   localparam int         SLOT_W     = 5;
endpackage

// file: design/lcd_drive_control.sv
// LCD drive control: two control registers, clock select, display gating and pulse duty.
module lcd_drive_control
   import lcd_ctl_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        sub_clk_tick,
   input  wire logic [7:0]  addr,
   input  wire logic [7:0]  wdata,
   input  wire logic        wr,
   input  wire logic        rd,
   output logic [7:0]       rdata,
   input  wire logic [7:0]  ram_data,
   output logic [7:0]       seg_data,
   output logic             drive_power_switch,
   output logic             display_function_run,
   output logic             show_ram_contents,
   output logic             drive_waveform_b_sel,
   output logic [3:0]       op_clk_sel,
   output logic [3:0]       pulse_duty,
   output logic             op_clk_tick,
   output logic             charge_pulse
);
   // ************************************************
   // Access decode
   // ************************************************
   logic       hit_ctl;
   logic       hit_ctl2;
   logic       wr_ctl;
   logic       wr_ctl2;
   logic       rd_ctl;
   logic       rd_ctl2;

   // Accesses to any other address are ignored.
   always_comb
   begin
      hit_ctl  = (addr == ADDR_LCD_CONTROL);
      hit_ctl2 = (addr == ADDR_LCD_CONTROL_SECOND);
      wr_ctl   = wr & hit_ctl;
      wr_ctl2  = wr & hit_ctl2;
      rd_ctl   = rd & hit_ctl;
      rd_ctl2  = rd & hit_ctl2;
   end

   // ************************************************
   // Control register
   // ************************************************
   logic [7:0] ctl_r;
   logic [7:0] ctl_nxt;

   always_comb
   begin
      ctl_nxt = ctl_r;
      if (wr_ctl)
      begin
         ctl_nxt = (wdata & ~CTL_RO_MASK) | CTL_RESET;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctl_r <= CTL_RESET;
      end
      else
      begin
         ctl_r <= ctl_nxt;
      end
   end

   // ************************************************
   // Second control register
   // ************************************************
   logic [7:0] ctl2_r;
   logic [7:0] ctl2_nxt;

   always_comb
   begin
      ctl2_nxt = ctl2_r;
      if (wr_ctl2)
      begin
         ctl2_nxt = (wdata & ~CTL2_RO_MASK) | CTL2_RESET;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         ctl2_r <= CTL2_RESET;
      end
      else
      begin
         ctl2_r <= ctl2_nxt;
      end
   end

   // ************************************************
   // Read data
   // ************************************************
   logic [7:0] rdata_r;
   logic [7:0] rdata_nxt;

   // Read data stand for one cycle and are zero otherwise.
   always_comb
   begin
      rdata_nxt = 8'h00;
      if (rd_ctl)
      begin
         rdata_nxt = ctl_r;
      end
      else if (rd_ctl2)
      begin
         rdata_nxt = ctl2_r;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         rdata_r <= 8'h00;
      end
      else
      begin
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata = rdata_r;

   // ************************************************
   // Control outputs
   // ************************************************
   // Drive power bit
   assign drive_power_switch   = ctl_r[POS_POWER];
   assign display_function_run = ctl_r[POS_RUN];
   assign show_ram_contents    = ctl_r[POS_SHOW];
   assign drive_waveform_b_sel = ctl2_r[POS_WAVE_B];
   assign op_clk_sel           = ctl_r[POS_CKS_HI:POS_CKS_LO];
   assign pulse_duty           = ctl2_r[POS_DUTY_HI:POS_DUTY_LO];

   // ************************************************
   // System clock divider chain
   // ************************************************
   logic [8:0] sys_t;
   logic [2:0] sub_t;

   assign sys_t[0] = 1'b1;
   assign sub_t[0] = sub_clk_tick;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_sys
         clk_div_stage u_sys
         (
            .clk      (clk),
            .rst      (rst),
            .tick_in  (sys_t[gi]),
            .tick_out (sys_t[gi+1])
         );
      end

      // ************************************************
      // Sub-clock divider chain
      // ************************************************
      for (gi = 0; gi < 2; gi++)
      begin : g_sub
         clk_div_stage u_sub
         (
            .clk      (clk),
            .rst      (rst),
            .tick_in  (sub_t[gi]),
            .tick_out (sub_t[gi+1])
         );
      end
   endgenerate

   // ************************************************
   // Operating clock select
   // ************************************************
   logic src_tick;
   logic tick_r;
   logic tick_nxt;

   always_comb
   begin
      src_tick = 1'b0;
      case (ctl_r[POS_CKS_HI:POS_CKS_LO])
         4'h0:    src_tick = sub_t[0];
         4'h1:    src_tick = sub_t[1];
         4'h2:    src_tick = sub_t[2];
         4'h3:    src_tick = sub_t[2];
         4'h4:    src_tick = sub_t[0];
         4'h5:    src_tick = sub_t[1];
         4'h6:    src_tick = sub_t[2];
         4'h7:    src_tick = sub_t[2];
         4'h8:    src_tick = sys_t[1];
         4'h9:    src_tick = sys_t[2];
         4'ha:    src_tick = sys_t[3];
         4'hb:    src_tick = sys_t[4];
         4'hc:    src_tick = sys_t[5];
         4'hd:    src_tick = sys_t[6];
         4'he:    src_tick = sys_t[7];
         4'hf:    src_tick = sys_t[8];
         default: src_tick = 1'b0;
      endcase
   end

   always_comb
   begin
      tick_nxt = src_tick & ctl_r[POS_RUN];
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         tick_r <= 1'b0;
      end
      else
      begin
         tick_r <= tick_nxt;
      end
   end

   assign op_clk_tick = tick_r;

   // ************************************************
   // Segment data
   // ************************************************
   logic [7:0] seg_r;
   logic [7:0] seg_nxt;

   always_comb
   begin
      seg_nxt = 8'h00;
      if (ctl_r[POS_RUN] && ctl_r[POS_SHOW])
      begin
         seg_nxt = ram_data;
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         seg_r <= 8'h00;
      end
      else
      begin
         seg_r <= seg_nxt;
      end
   end

   assign seg_data = seg_r;

   // ************************************************
   // Charge/discharge pulse
   // ************************************************
   logic       duty_run;
   logic [3:0] duty_code;

   // Pulses only with drive power on
   always_comb
   begin
      duty_run  = ctl_r[POS_RUN] & ctl_r[POS_POWER];
      duty_code = ctl2_r[POS_DUTY_HI:POS_DUTY_LO];
   end

   duty_pulse_gen u_duty
   (
      .clk       (clk),
      .rst       (rst),
      .run       (duty_run),
      .tick      (tick_r),
      .duty_code (duty_code),
      .pulse     (charge_pulse)
   );
endmodule

// file: sim/lcd_drive_control_assertions.sv
// Concurrent checks on the LCD drive control ports.
module lcd_drive_control_assertions
(
   input wire logic       clk,
   input wire logic       rst,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic [7:0] ram_data,
   input wire logic [7:0] seg_data,
   input wire logic       drive_power_switch,
   input wire logic       display_function_run,
   input wire logic       show_ram_contents,
   input wire logic       drive_waveform_b_sel,
   input wire logic [3:0] op_clk_sel,
   input wire logic [3:0] pulse_duty,
   input wire logic       op_clk_tick,
   input wire logic       charge_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   a_ctl_write: assert property (wr && addr == 8'hc1 |=>
      {drive_power_switch, display_function_run, show_ram_contents, op_clk_sel} == $past(wdata[6:0]))
      else $error("control write not applied");
   a_ctl2_write: assert property (wr && addr == 8'hc2 |=>
      {drive_waveform_b_sel, pulse_duty} == {$past(wdata[7]), $past(wdata[3:0])})
      else $error("second control write not applied");
   a_seg_gate: assert property (seg_data ==
      ($past(show_ram_contents && display_function_run) ? $past(ram_data) : 8'h00))
      else $error("segment data not gated");
   a_halt_tick: assert property (!display_function_run && !$past(display_function_run) |-> !op_clk_tick)
      else $error("tick while halted");
   a_power_off: assert property (!drive_power_switch && !$past(drive_power_switch) |-> !charge_pulse)
      else $error("pulse with power off");
   a_div_two: assert property (op_clk_tick && op_clk_sel == 4'h8 && $past(op_clk_sel) == 4'h8
      ##1 (display_function_run && op_clk_sel == 4'h8)[*2] |-> op_clk_tick && !$past(op_clk_tick))
      else $error("divide by two wrong");
   c_slow_tick: cover property (op_clk_tick && op_clk_sel == 4'hf);
   c_short_duty: cover property (charge_pulse && pulse_duty == 4'hc);
   c_show_ram: cover property (seg_data != 8'h00);
endmodule

// file: sim/lcd_panel_model.sv
// Panel stand-in that counts drive ticks and charge pulse cycles.
module lcd_panel_model
(
   input  wire logic        clk,
   input  wire logic        clr,
   input  wire logic        op_clk_tick,
   input  wire logic        charge_pulse,
   output logic      [15:0] tick_cnt,
   output logic      [15:0] pulse_cnt
);
   timeunit 1ns;
   timeprecision 1ps;
   always_ff @(posedge clk)
   begin
      tick_cnt  <= clr ? 16'h0000 : tick_cnt + 16'(op_clk_tick);
      pulse_cnt <= clr ? 16'h0000 : pulse_cnt + 16'(charge_pulse);
   end
endmodule

// file: sim/tb.sv
// Testbench for the LCD drive control.
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst, sub_clk_tick, wr, rd, clr, op_clk_tick, charge_pulse;
   logic        drive_power_switch, display_function_run, show_ram_contents, drive_waveform_b_sel;
   logic [7:0]  addr, wdata, ram_data, rdata, seg_data;
   logic [3:0]  op_clk_sel, pulse_duty;
   logic [15:0] tick_cnt, pulse_cnt, cyc;
   int          miscompares, compares;
   lcd_drive_control dut (.*);
   lcd_panel_model pnl (.*);
   task automatic chk(string n, logic [15:0] s, logic [15:0] e);
      compares++;
      if (s !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic wreg(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(logic [7:0] a, logic [7:0] e);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("rdata", {8'h00, rdata}, {8'h00, e});
   endtask
   task automatic win(int n, logic [15:0] et, logic [15:0] ep);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (n) @(posedge clk);
      #1 chk("ticks", tick_cnt, et);
      chk("pulse", pulse_cnt, ep);
   endtask
   task automatic give_verdict();
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc <= cyc + 16'h0001;
      sub_clk_tick <= cyc[2:0] == 3'h0;
      if (cyc == 16'h9c40)
      begin
         miscompares++;
         give_verdict();
      end
   end
   initial
   begin
      {rst, wr, rd, clr, sub_clk_tick, addr, wdata, cyc} = {5'h10, 32'h0};
      {ram_data, miscompares, compares} = {8'h5a, 64'h0};
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rreg(8'hc1, 8'h80);
      rreg(8'hc2, 8'h60);
      rreg(8'hc3, 8'h00);
      win(64, 16'h0000, 16'h0000);
      chk("seg", {8'h00, seg_data}, 16'h0000);
      wreg(8'hc1, 8'h70);
      rreg(8'hc1, 8'hf0);
      chk("bits", {13'h0000, drive_power_switch, display_function_run, show_ram_contents}, 16'h0007);
      chk("sel", {12'h000, op_clk_sel}, 16'h0000);
      chk("seg", {8'h00, seg_data}, 16'h005a);
      wreg(8'hc2, 8'h9f);
      rreg(8'hc2, 8'hff);
      chk("wave", {15'h0000, drive_waveform_b_sel}, 16'h0001);
      chk("duty", {12'h000, pulse_duty}, 16'h000f);
      $display("test registers done");
      for (int c = 0; c < 16; c++)
      begin
         if (c < 4 || c > 7)
         begin
            wreg(8'hc1, 8'h20 | 8'(c));
            win(512, c > 7 ? 16'(512 >> (c - 7)) : 16'(64 >> (c > 1 ? 2 : c)), 16'h0000);
            chk("seg", {8'h00, seg_data}, 16'h0000);
            chk("sel", {12'h000, op_clk_sel}, 16'(c));
         end
      end
      $display("test clock select done");
      wreg(8'hc1, 8'h68);
      for (int d = 0; d < 16; d++)
      begin
         wreg(8'hc2, 8'(d));
         repeat (64) @(posedge clk);
         win(1024, 16'd512, 16'((d == 0 ? 32 : d < 7 ? d * 4 : d == 7 ? 0 : d < 12 ? 2 : 1) * 32));
      end
      chk("wave", {15'h0000, drive_waveform_b_sel}, 16'h0000);
      $display("test duty done");
      give_verdict();
   end
endmodule
bind lcd_drive_control lcd_drive_control_assertions chk_i
(
   .clk                  (clk),
   .rst                  (rst),
   .addr                 (addr),
   .wdata                (wdata),
   .wr                   (wr),
   .ram_data             (ram_data),
   .seg_data             (seg_data),
   .drive_power_switch   (drive_power_switch),
   .display_function_run (display_function_run),
   .show_ram_contents    (show_ram_contents),
   .drive_waveform_b_sel (drive_waveform_b_sel),
   .op_clk_sel           (op_clk_sel),
   .pulse_duty           (pulse_duty),
   .op_clk_tick          (op_clk_tick),
   .charge_pulse         (charge_pulse)
);
